// ---- hdl/sbc_divider.v ----
`timescale 1ns/100ps

// Free running divider that emits a one-cycle enable pulse every DIV clock cycles.
module sbc_divider
#(
    parameter DIV = 16
)
(
    input  wire clk_i,
    input  wire arst_n_i,
    output reg  tick_o
);

    // Cycle counter within one division period.
    reg [7:0] cnt_q;

    // Count down and pulse when the period wraps.
    always @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            cnt_q  <= 8'h00;
            tick_o <= 1'b0;
        end
        else if (cnt_q == 8'h00)
        begin
            cnt_q  <= DIV[7:0] - 8'h01;
            tick_o <= 1'b1;
        end
        else
        begin
            cnt_q  <= cnt_q - 8'h01;
            tick_o <= 1'b0;
        end
    end

endmodule

// ---- hdl/sbc_stab_timer.v ----
`timescale 1ns/100ps
`include "sbc_regs.vh"

// Prescaler feeding an 8-bit down timer; the timer underflow ends the restart wait.
module sbc_stab_timer
(
    input  wire       clk_i,
    input  wire       arst_n_i,
    input  wire       tick_i,
    input  wire       load_def_i,
    input  wire       wr_pre_i,
    input  wire       wr_t1_i,
    input  wire [7:0] wdata_i,
    output wire [7:0] pre_o,
    output wire [7:0] t1_o,
    output reg        under_o
);

    // Live counters and their reload latches.
    reg [7:0] pre_cnt_q;
    reg [7:0] pre_rld_q;
    reg [7:0] t1_cnt_q;
    reg [7:0] t1_rld_q;

    assign pre_o = pre_cnt_q;
    assign t1_o  = t1_cnt_q;

    // A default load or a software write takes priority over counting.
    always @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            pre_cnt_q <= `SBC_PRE_DEFAULT;
            pre_rld_q <= `SBC_PRE_DEFAULT;
            t1_cnt_q  <= `SBC_T1_DEFAULT;
            t1_rld_q  <= `SBC_T1_DEFAULT;
            under_o   <= 1'b0;
        end
        else
        begin
            under_o <= 1'b0;
            if (load_def_i)
            begin
                // Fixed restart wait: prescaler and timer both get their defaults.
                pre_cnt_q <= `SBC_PRE_DEFAULT;
                pre_rld_q <= `SBC_PRE_DEFAULT;
                t1_cnt_q  <= `SBC_T1_DEFAULT;
                t1_rld_q  <= `SBC_T1_DEFAULT;
            end
            else if (wr_pre_i || wr_t1_i)
            begin
                // Software writes load counter and latch together.
                if (wr_pre_i)
                begin
                    pre_cnt_q <= wdata_i;
                    pre_rld_q <= wdata_i;
                end
                if (wr_t1_i)
                begin
                    t1_cnt_q <= wdata_i;
                    t1_rld_q <= wdata_i;
                end
            end
            else if (tick_i)
            begin
                if (pre_cnt_q == 8'h00)
                begin
                    // Prescaler wraps and clocks the timer once.
                    pre_cnt_q <= pre_rld_q;
                    if (t1_cnt_q == 8'h00)
                    begin
                        t1_cnt_q <= t1_rld_q;
                        under_o  <= 1'b1;
                    end
                    else
                    begin
                        t1_cnt_q <= t1_cnt_q - 8'h01;
                    end
                end
                else
                begin
                    pre_cnt_q <= pre_cnt_q - 8'h01;
                end
            end
        end
    end

endmodule

// ---- hdl/sbc_standby_clock.v ----
`timescale 1ns/100ps
`include "sbc_regs.vh"

// Behaviour
// - Stop instruction halts clock high, stops oscillator
// - Stop entry, bit zero: timer 01, prescaler FF
// - Stop entry, bit one: timer, prescaler untouched
// - Stop and restart wait: prescaler fed by f/16
// - Interrupt restarts oscillator, clock after timer underflow
// - Reset ends stop with no timed wait
// - Flash variant: regulator low power during stop
// - Wait instruction halts clock high, oscillator runs
// - Wait mode: reset or interrupt restarts immediately
// - Start on on-chip oscillator, mode bit selects later
// - Mode bits five, one, zero writable once
module sbc_standby_clock
#(
    parameter FLASH_VARIANT = 1,
    parameter WAKE_CYC      = `SBC_FLASH_WAKE_CYC
)
(
    input  wire        REF_CLK_I,
    input  wire        ARST_N_I,
    input  wire        INT_REQ_I,
    input  wire        PSEL_I,
    input  wire        PENABLE_I,
    input  wire        PWRITE_I,
    input  wire [9:0]  PADDR_I,
    input  wire [31:0] PWDATA_I,
    output reg  [31:0] PRDATA_O,
    output reg         PREADY_O,
    output reg         PSLVERR_O,
    output reg         PHI_O,
    output reg         XIN_OSC_EN_O,
    output reg         REG_LOWPWR_O,
    output reg  [1:0]  OSC_SEL_O,
    output reg  [1:0]  CPU_MODE_O
);

    // One-hot standby states.
    localparam [3:0] ST_RUN  = 4'b0001;
    localparam [3:0] ST_STOP = 4'b0010;
    localparam [3:0] ST_STAB = 4'b0100;
    localparam [3:0] ST_WAIT = 4'b1000;

    // Returns one when the word index names a mapped register.
    function reg_hit;
        input [7:0] idx;
        begin
            reg_hit = (idx == `SBC_IDX_PRESC) || (idx == `SBC_IDX_TIMER) ||
                      (idx == `SBC_IDX_MODE)  || (idx == `SBC_IDX_CTRL)  ||
                      (idx == `SBC_IDX_CMD)   || (idx == `SBC_IDX_STATUS);
        end
    endfunction

    // Standby state register.
    reg  [3:0]  state_q;
    // Interrupt request synchroniser stages.
    reg         int_s1_q;
    reg         int_s2_q;
    // Software registers.
    reg  [7:0]  mode_q;
    reg         mode_lock_q;
    reg  [7:0]  ctrl_q;
    // Restart wait length check for the flash variant.
    reg  [13:0] wake_cnt_q;
    reg         short_wake_q;
    // Register bus decode.
    wire [7:0]  idx;
    wire        setup;
    wire        wr_acc;
    wire        wr_presc;
    wire        wr_timer;
    wire        wr_mode;
    wire        wr_ctrl;
    wire        wr_cmd;
    // Clock enables and timer hookup.
    wire        phi_tick;
    wire        tick16;
    wire        force16;
    wire        presc_tick;
    wire        count_en;
    wire        load_def;
    wire        t1_under;
    wire [7:0]  pre_val;
    wire [7:0]  t1_val;
    wire        cmd_stop;
    wire        cmd_wait;
    wire        wake;
    reg  [7:0]  rd_mux;

    // Word index of the bus address; the low two address bits are ignored.
    assign idx      = PADDR_I[9:2];
    // Setup phase of an APB transfer.
    assign setup    = PSEL_I && !PENABLE_I;
    // A write takes effect on the edge that completes its access phase.
    assign wr_acc   = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I;
    assign wr_presc = wr_acc && (idx == `SBC_IDX_PRESC);
    assign wr_timer = wr_acc && (idx == `SBC_IDX_TIMER);
    assign wr_mode  = wr_acc && (idx == `SBC_IDX_MODE);
    assign wr_ctrl  = wr_acc && (idx == `SBC_IDX_CTRL);
    assign wr_cmd   = wr_acc && (idx == `SBC_IDX_CMD);
    // Standby instructions are taken only while running.
    assign cmd_stop = wr_cmd && (PWDATA_I[7:0] == `SBC_CMD_STOP) && (state_q == ST_RUN);
    assign cmd_wait = wr_cmd && (PWDATA_I[7:0] == `SBC_CMD_WAIT) && (state_q == ST_RUN);
    // Only the second synchroniser stage is read by logic.
    assign wake     = int_s2_q;

    // Fixed defaults go into the stabilisation timer only when the set bit is zero.
    assign load_def = cmd_stop && !ctrl_q[`SBC_CTRL_STABSET];

    // In stop and the restart wait the prescaler input is forced to f/16.
    assign force16    = (state_q == ST_STOP) || (state_q == ST_STAB);
    assign presc_tick = (force16 || !ctrl_q[`SBC_CTRL_FASTSRC]) ? tick16 : 1'b1;
    // With the oscillator halted the timer has no clock to count.
    assign count_en   = (state_q != ST_STOP);

    // Enable for each half period of the internal clock.
    sbc_divider
    #(
        .DIV      (`SBC_PHI_HALF)
    )
    u_phi_div
    (
        .clk_i    (REF_CLK_I),
        .arst_n_i (ARST_N_I),
        .tick_o   (phi_tick)
    );

    // Main clock divided by sixteen for the prescaler.
    sbc_divider
    #(
        .DIV      (`SBC_PRE_FORCE_DIV)
    )
    u_pre_div
    (
        .clk_i    (REF_CLK_I),
        .arst_n_i (ARST_N_I),
        .tick_o   (tick16)
    );

    // Prescaler and timer that time the restart wait.
    sbc_stab_timer u_stab
    (
        .clk_i      (REF_CLK_I),
        .arst_n_i   (ARST_N_I),
        .tick_i     (presc_tick && count_en),
        .load_def_i (load_def),
        .wr_pre_i   (wr_presc),
        .wr_t1_i    (wr_timer),
        .wdata_i    (PWDATA_I[7:0]),
        .pre_o      (pre_val),
        .t1_o       (t1_val),
        .under_o    (t1_under)
    );

    // Two-stage synchroniser for the external interrupt request pin.
    always @(posedge REF_CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            int_s1_q <= 1'b0;
            int_s2_q <= 1'b0;
        end
        else
        begin
            int_s1_q <= INT_REQ_I;
            int_s2_q <= int_s1_q;
        end
    end

    // Standby state machine with oscillator and regulator control.
    // Reset returns every state straight to run with the oscillator on and no timed wait.
    always @(posedge REF_CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            state_q      <= ST_RUN;
            XIN_OSC_EN_O <= 1'b1;
            REG_LOWPWR_O <= 1'b0;
        end
        else
        begin
            case (state_q)
                ST_RUN:
                begin
                    // Stop halts the oscillator and, on flash parts, lowers the regulator.
                    if (cmd_stop)
                    begin
                        state_q      <= ST_STOP;
                        XIN_OSC_EN_O <= 1'b0;
                        REG_LOWPWR_O <= (FLASH_VARIANT != 0);
                    end
                    // Wait gates only the internal clock; the oscillator keeps running.
                    else if (cmd_wait)
                    begin
                        state_q <= ST_WAIT;
                    end
                end
                ST_STOP:
                begin
                    // Interrupt restarts the oscillator and starts the timed wait.
                    // Software must have enabled the interrupt beforehand.
                    if (wake)
                    begin
                        state_q      <= ST_STAB;
                        XIN_OSC_EN_O <= 1'b1;
                        REG_LOWPWR_O <= 1'b0;
                    end
                end
                ST_STAB:
                begin
                    // Clock supply resumes only on the timer underflow.
                    if (t1_under)
                    begin
                        state_q <= ST_RUN;
                    end
                end
                ST_WAIT:
                begin
                    // Oscillator never stopped, so resume at once.
                    if (wake)
                    begin
                        state_q <= ST_RUN;
                    end
                end
                default:
                begin
                    state_q <= ST_RUN;
                end
            endcase
        end
    end

    // Internal clock: it may only fall while running, so it always halts high
    // after a whole pulse and restarts with a full-length low phase.
    always @(posedge REF_CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            PHI_O <= 1'b1;
        end
        else if (phi_tick)
        begin
            if (!PHI_O)
            begin
                PHI_O <= 1'b1;
            end
            else if (state_q == ST_RUN)
            begin
                PHI_O <= 1'b0;
            end
        end
    end

    // Measures the restart wait and flags one shorter than the flash supply needs.
    always @(posedge REF_CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            wake_cnt_q   <= 14'h0000;
            short_wake_q <= 1'b0;
        end
        else if (cmd_stop)
        begin
            wake_cnt_q   <= 14'h0000;
            short_wake_q <= 1'b0;
        end
        else if (state_q == ST_STAB)
        begin
            if (wake_cnt_q != 14'h3FFF)
            begin
                wake_cnt_q <= wake_cnt_q + 14'h0001;
            end
            // Flag is only meaningful on flash parts.
            if (t1_under && (FLASH_VARIANT != 0) && ({18'h0_0000, wake_cnt_q} < WAKE_CYC - 1))
            begin
                short_wake_q <= 1'b1;
            end
        end
    end

    // Mode register: oscillator select and operating mode bits take one write only.
    // The external-clock case relies on software writing the ceramic code here.
    always @(posedge REF_CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            mode_q      <= `SBC_MODE_RESET;
            mode_lock_q <= 1'b0;
        end
        else if (wr_mode)
        begin
            mode_q[7:6] <= PWDATA_I[7:6];
            mode_q[4:2] <= PWDATA_I[4:2];
            if (!mode_lock_q)
            begin
                mode_q[5]   <= PWDATA_I[5];
                mode_q[1:0] <= PWDATA_I[1:0];
                mode_lock_q <= 1'b1;
            end
        end
    end

    // Source and mode outputs: on-chip oscillator until the mode bit is committed.
    always @(posedge REF_CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            OSC_SEL_O  <= `SBC_SRC_ONCHIP;
            CPU_MODE_O <= 2'b00;
        end
        else
        begin
            CPU_MODE_O <= mode_q[1:0];
            if (mode_lock_q)
            begin
                OSC_SEL_O <= mode_q[`SBC_MODE_OSCSEL] ? `SBC_SRC_RC : `SBC_SRC_CERAMIC;
            end
        end
    end

    // Control register: stabilisation-time set bit and prescaler source.
    always @(posedge REF_CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            ctrl_q <= `SBC_CTRL_RESET;
        end
        else if (wr_ctrl)
        begin
            ctrl_q <= {6'b00_0000, PWDATA_I[1:0]};
        end
    end

    // Read data selection; unmapped and write-only words read as zero.
    always @*
    begin
        rd_mux = 8'h00;
        case (idx)
            `SBC_IDX_PRESC:  rd_mux = pre_val;
            `SBC_IDX_TIMER:  rd_mux = t1_val;
            `SBC_IDX_MODE:   rd_mux = mode_q;
            `SBC_IDX_CTRL:   rd_mux = ctrl_q;
            `SBC_IDX_STATUS: rd_mux = {mode_lock_q, short_wake_q, REG_LOWPWR_O, XIN_OSC_EN_O, state_q};
            default:         rd_mux = 8'h00;
        endcase
    end

    // APB slave: ready rises for the access phase that follows each setup cycle,
    // so every transfer completes with no wait state.
    always @(posedge REF_CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            PREADY_O  <= 1'b0;
            PSLVERR_O <= 1'b0;
            PRDATA_O  <= 32'h0000_0000;
        end
        else if (setup)
        begin
            PREADY_O  <= 1'b1;
            PSLVERR_O <= !reg_hit(idx);
            PRDATA_O  <= {24'h00_0000, rd_mux};
        end
        else
        begin
            PREADY_O  <= 1'b0;
            PSLVERR_O <= 1'b0;
        end
    end

endmodule

// ---- pkg/sbc_regs.vh ----
// Register map, field positions, reset values and timing counts of the standby clock control.
`ifndef SBC_REGS_VH
`define SBC_REGS_VH

// Register indices; the byte address of a register is four times its index.
`define SBC_IDX_PRESC       8'h28
`define SBC_IDX_TIMER       8'h29
`define SBC_IDX_MODE        8'h3B
`define SBC_IDX_CTRL        8'h40
`define SBC_IDX_CMD         8'h41
`define SBC_IDX_STATUS      8'h42

// Mode register fields and reset value.
`define SBC_MODE_OSCSEL     5
`define SBC_MODE_RESET      8'h80

// Control register fields and reset value.
`define SBC_CTRL_STABSET    0
`define SBC_CTRL_FASTSRC    1
`define SBC_CTRL_RESET      8'h00

// Standby command codes written to the command register.
`define SBC_CMD_STOP        8'h01
`define SBC_CMD_WAIT        8'h02

// Values loaded into the stabilisation timer and prescaler on stop entry.
`define SBC_T1_DEFAULT      8'h01
`define SBC_PRE_DEFAULT     8'hFF

// Clock division ratios, in cycles of the main clock.
`define SBC_PHI_HALF        2
`define SBC_PRE_FORCE_DIV   16

// Oscillator source codes.
`define SBC_SRC_ONCHIP      2'b00
`define SBC_SRC_CERAMIC     2'b01
`define SBC_SRC_RC          2'b10

// Least restart wait of the flash variant, and the main clock rate.
`define SBC_FLASH_WAKE_US   100
`define SBC_CLK_MHZ         125
`define SBC_FLASH_WAKE_CYC  (`SBC_FLASH_WAKE_US * `SBC_CLK_MHZ)

`endif

// ---- testbench/sbc_standby_clock_sva.sv ----
`timescale 1ns/100ps
`include "sbc_regs.vh"

// Port-level checker of the standby clock control.
module sbc_standby_clock_sva
#(
    parameter FLASH_VARIANT = 1
)
(
    input logic        REF_CLK_I,
    input logic        ARST_N_I,
    input logic        INT_REQ_I,
    input logic        PSEL_I,
    input logic        PENABLE_I,
    input logic        PWRITE_I,
    input logic [9:0]  PADDR_I,
    input logic [31:0] PWDATA_I,
    input logic [31:0] PRDATA_O,
    input logic        PREADY_O,
    input logic        PSLVERR_O,
    input logic        PHI_O,
    input logic        XIN_OSC_EN_O,
    input logic        REG_LOWPWR_O,
    input logic [1:0]  OSC_SEL_O,
    input logic [1:0]  CPU_MODE_O
);
    logic       lk_q;                        // A mode write has been taken.
    logic       lk2_q;                       // The same, one cycle later.
    wire  [7:0] idx     = PADDR_I[9:2];      // Word index of the request.
    wire        mode_wr = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I && (idx == `SBC_IDX_MODE);

    default clocking cb @(posedge REF_CLK_I);
    endclocking
    default disable iff (!ARST_N_I);

    // Remembers the first mode write, where the write-once bits lock.
    always @(posedge REF_CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            lk_q  <= 1'b0;
            lk2_q <= 1'b0;
        end
        else
        begin
            lk_q  <= lk_q | mode_wr;
            lk2_q <= lk_q;
        end
    end

    // The internal clock stays high for a run of cycles.
    sequence phi_held_s;
        PHI_O [*8];
    endsequence

    // The oscillator has just been started again.
    sequence osc_start_s;
        $rose(XIN_OSC_EN_O);
    endsequence

    stop_phi_high_a: assert property (!XIN_OSC_EN_O && !$past(XIN_OSC_EN_O, 3) |-> PHI_O)
        else $error("Internal clock low in stop.");
    wake_phi_hold_a: assert property (osc_start_s |-> phi_held_s)
        else $error("Internal clock released before the restart wait.");
    int_wake_a: assert property (!XIN_OSC_EN_O && INT_REQ_I |-> ##[1:5] XIN_OSC_EN_O)
        else $error("Interrupt did not restart the oscillator.");
    regulator_mode_a: assert property (REG_LOWPWR_O == ((FLASH_VARIANT != 0) && !XIN_OSC_EN_O))
        else $error("Regulator mode does not follow stop.");
    phi_whole_a: assert property ($changed(PHI_O) |=> $stable(PHI_O))
        else $error("Internal clock phase shorter than two cycles.");
    osc_onchip_a: assert property (!lk_q |-> OSC_SEL_O == `SBC_SRC_ONCHIP)
        else $error("Source left on-chip oscillator before a mode write.");
    mode_lock_a: assert property ($past(lk2_q) |-> $stable(CPU_MODE_O) && $stable(OSC_SEL_O))
        else $error("Locked mode bits changed.");
    mode_first_a: assert property (mode_wr && !lk_q |=> ##1 CPU_MODE_O == $past(PWDATA_I[1:0], 2))
        else $error("First mode write not taken.");
    apb_ready_a: assert property (PSEL_I && !PENABLE_I |=> PREADY_O)
        else $error("No ready after setup.");
    apb_only_a: assert property (PREADY_O |-> $past(PSEL_I) && !$past(PENABLE_I))
        else $error("Ready without setup.");
    apb_err_a: assert property (PREADY_O |-> PSLVERR_O == !(idx inside {`SBC_IDX_PRESC, `SBC_IDX_TIMER,
        `SBC_IDX_MODE, `SBC_IDX_CTRL, `SBC_IDX_CMD, `SBC_IDX_STATUS}))
        else $error("Error response does not match the map.");
endmodule

bind sbc_standby_clock sbc_standby_clock_sva #(.FLASH_VARIANT(FLASH_VARIANT)) sbc_sva_inst (
    .REF_CLK_I(REF_CLK_I), .ARST_N_I(ARST_N_I), .INT_REQ_I(INT_REQ_I), .PSEL_I(PSEL_I),
    .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I),
    .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .PHI_O(PHI_O),
    .XIN_OSC_EN_O(XIN_OSC_EN_O), .REG_LOWPWR_O(REG_LOWPWR_O), .OSC_SEL_O(OSC_SEL_O),
    .CPU_MODE_O(CPU_MODE_O));

// ---- testbench/sbc_standby_clock_tb_top.sv ----
`timescale 1ns/100ps
`include "sbc_regs.vh"

// Self-checking bench of the standby clock control with a register model.
module sbc_standby_clock_tb_top;
    logic        clk, arst_n, int_req, psel, penable, pwrite;
    logic [9:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, phi, osc_en, lowpwr, err;
    logic [1:0]  osc_sel, cpu_mode;
    int          error_cnt, samples_checked, cyc;
    logic [7:0]  mode_mdl;                   // Model of the mode register.
    logic        lock_mdl;                   // Model of the write-once lock.

    sbc_standby_clock #(.FLASH_VARIANT(1), .WAKE_CYC(64)) sbc_standby_clock_inst (
        .REF_CLK_I(clk), .ARST_N_I(arst_n), .INT_REQ_I(int_req), .PSEL_I(psel), .PENABLE_I(penable),
        .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
        .PSLVERR_O(pslverr), .PHI_O(phi), .XIN_OSC_EN_O(osc_en), .REG_LOWPWR_O(lowpwr),
        .OSC_SEL_O(osc_sel), .CPU_MODE_O(cpu_mode));

    // Main clock, 8 ns period.
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Prints the counts and the verdict, then stops.
    task automatic complete_run();
        $display("Checks %0d, mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Cuts a hung run short.
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 40000)
        begin
            error_cnt++;
            complete_run();
        end
    end

    // Compares one value with the model.
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e)
        begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Checks that a cycle count falls inside its window.
    task automatic rng(input string nm, input int lo, input int hi, input int n);
        samples_checked++;
        if (n < lo || n > hi)
        begin
            error_cnt++;
            $display("MISMATCH %s expected %0d..%0d seen %0d", nm, lo, hi, n);
        end
    endtask

    // Holds reset for three cycles.
    task automatic rst();
        arst_n <= 1'b0;
        mode_mdl = `SBC_MODE_RESET;
        lock_mdl = 1'b0;
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
    endtask

    // One APB transfer; read data and error land in rd and err.
    task automatic apb(input logic wr, input logic [7:0] ix, input logic [7:0] wd);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {ix, 2'b00};
        pwdata  <= {24'h00_0000, wd};
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
        end
        while (pready !== 1'b1);
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // Register model: bits 5, 1 and 0 of the mode word take the first write only.
        if (wr && ix == `SBC_IDX_MODE)
        begin
            mode_mdl = lock_mdl ? ((wd & 8'hDC) | (mode_mdl & 8'h23)) : wd;
            lock_mdl = 1'b1;
        end
    endtask

    // Reads a register and compares the masked low byte.
    task automatic rdc(input string nm, input logic [7:0] ix, input logic [7:0] mk, input logic [7:0] e);
        apb(1'b0, ix, 8'h00);
        chk(nm, {24'h00_0000, e}, rd & {24'h00_0000, mk});
    endtask

    // Raises the wake request and counts cycles until the internal clock falls.
    task automatic wake(output int n);
        int_req <= 1'b1;
        n = 0;
        while (phi !== 1'b0 && n < 20000)
        begin
            @(posedge clk);
            n++;
        end
        int_req <= 1'b0;
    endtask

    // Main sequence.
    initial
    begin
        int         n, p, t;
        logic [7:0] m, m2;
        arst_n = 1'b0; int_req = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 10'h000; pwdata = 32'h0000_0000; error_cnt = 0; samples_checked = 0; cyc = 0;
        void'($urandom(32'h0000_710c));
        rst();
        rdc("mode", `SBC_IDX_MODE, 8'hFF, `SBC_MODE_RESET);
        rdc("timer", `SBC_IDX_TIMER, 8'hFF, `SBC_T1_DEFAULT);
        rdc("status", `SBC_IDX_STATUS, 8'hFF, 8'h11);
        chk("osc_sel", `SBC_SRC_ONCHIP, osc_sel);
        apb(1'b0, 8'h10, 8'h00);
        chk("slverr", 1, err);
        chk("unmapped", 0, rd);
        // Write-once mode bits: second write may change only the free bits.
        m  = 8'($urandom) | 8'h20;
        m2 = ~m;
        apb(1'b1, `SBC_IDX_MODE, m);
        apb(1'b1, `SBC_IDX_MODE, m2);
        rdc("mode", `SBC_IDX_MODE, 8'hFF, mode_mdl);
        chk("osc_sel", `SBC_SRC_RC, osc_sel);
        chk("cpu_mode", m[1:0], cpu_mode);
        // Stop with default wait, prescaler on the fast source outside stop.
        apb(1'b1, `SBC_IDX_CTRL, 8'h02);
        apb(1'b1, `SBC_IDX_PRESC, 8'($urandom));
        apb(1'b1, `SBC_IDX_TIMER, 8'h05);
        apb(1'b1, `SBC_IDX_CMD, `SBC_CMD_STOP);
        repeat (4) @(posedge clk);
        chk("osc_en", 0, osc_en);
        chk("lowpwr", 1, lowpwr);
        chk("phi", 1, phi);
        rdc("timer", `SBC_IDX_TIMER, 8'hFF, `SBC_T1_DEFAULT);
        rdc("status", `SBC_IDX_STATUS, 8'h3F, 8'h22);
        wake(n);
        rng("stop_wait", 7936, 8448, n);
        rdc("status", `SBC_IDX_STATUS, 8'h7F, 8'h11);
        // Stop with software-programmed wait.
        p = $urandom_range(3, 1);
        t = $urandom_range(3, 1);
        apb(1'b1, `SBC_IDX_CTRL, 8'h01);
        apb(1'b1, `SBC_IDX_PRESC, 8'(p));
        apb(1'b1, `SBC_IDX_TIMER, 8'(t));
        apb(1'b1, `SBC_IDX_CMD, `SBC_CMD_STOP);
        repeat (4) @(posedge clk);
        wake(n);
        rng("prog_wait", ((p + 1) * (t + 1) - 2) * 16, (p + 1) * (t + 1) * 16 + 32, n);
        // Wait mode; a stop command inside it is ignored.
        apb(1'b1, `SBC_IDX_CMD, `SBC_CMD_WAIT);
        apb(1'b1, `SBC_IDX_CMD, `SBC_CMD_STOP);
        repeat (4) @(posedge clk);
        chk("osc_en", 1, osc_en);
        chk("phi", 1, phi);
        rdc("status", `SBC_IDX_STATUS, 8'h3F, 8'h18);
        wake(n);
        rng("wait_wake", 0, 12, n);
        // Reset ends stop at once.
        apb(1'b1, `SBC_IDX_CMD, `SBC_CMD_STOP);
        repeat (4) @(posedge clk);
        rst();
        chk("osc_en", 1, osc_en);
        wake(n);
        rng("reset_wake", 0, 6, n);
        rdc("status", `SBC_IDX_STATUS, 8'hFF, 8'h11);
        // Ceramic setting, as software does for an external clock.
        m = 8'($urandom) & 8'hDF;
        apb(1'b1, `SBC_IDX_MODE, m);
        rdc("mode", `SBC_IDX_MODE, 8'hFF, mode_mdl);
        chk("osc_sel", `SBC_SRC_CERAMIC, osc_sel);
        chk("cpu_mode", m[1:0], cpu_mode);
        complete_run();
    end
endmodule
